//--- logic/cwf_cfg.svh
// constants for the configuration write forwarding block
`ifndef CWF_CFG_SVH
`define CWF_CFG_SVH
`define CWF_CMD_CFG_RD   4'hA
`define CWF_CMD_CFG_WR   4'hB
`define CWF_CMD_MEM_RD   4'h6
`define CWF_CMD_MEM_RDL  4'hE
`define CWF_CMD_DAC      4'hD
`define CWF_CMD_SPECIAL  4'h1
`define CWF_DEV_ALL1     5'h1F
`define CWF_FUNC_ALL1    3'h7
`define CWF_TYPE0        2'h0
`define CWF_TYPE1        2'h1
`define CWF_BUS_LSB      16
`define CWF_DEV_LSB      11
`define CWF_FUNC_LSB     8
`define CWF_REG_LSB      2
`define CWF_IDSEL_LSB    16
`define CWF_IDSEL_W      4
`define CWF_TYPE_LSB     0
`define CWF_TYPE_W       2
`define CWF_DEV_W        5
`define CWF_FUNC_W       3
`define CWF_REG_W        6
`define CWF_ADDR_W       32
`endif

//--- logic/cwf_pkg.sv
// types for the configuration write forwarding block
package cwf_pkg;
   // address phase as seen on one bus
   typedef struct packed {
      logic        valid;
      logic [3:0]  cmd;
      logic [31:0] addr;
   } cwf_req_t;

   // claim decision for one request
   typedef enum {
      CWF_IGNORE,
      CWF_LOCAL,
      CWF_TO_TYPE0,
      CWF_PASS_TYPE1,
      CWF_TO_SPECIAL,
      CWF_PASS_MEM
   } cwf_action_t;
endpackage

//--- logic/cwf_bus_match.sv
// bus number window compare for type 1 configuration addresses
`timescale 1ns/1ps
module cwf_bus_match #(
   parameter int BUS_W = 8
) (
   // numbers compared
   input  wire logic [BUS_W-1:0] targetBus,
   input  wire logic [BUS_W-1:0] secBus,
   input  wire logic [BUS_W-1:0] subBus,
   // result
   output logic                  isSecondary,
   output logic                  isSubordinate
);
   // equal to secondary, or above it up to subordinate
   assign isSecondary   = (targetBus == secBus);
   assign isSubordinate = (targetBus > secBus) && (targetBus <= subBus);
endmodule

//--- logic/cwf_forward.sv
// primary to secondary command decode and forwarding for a bridge
`timescale 1ns/1ps
`include "cwf_cfg.svh"

module cwf_forward
   import cwf_pkg::*;
#(
   parameter int BUS_W = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // bus numbers and memory window hit from elsewhere in the bridge
   input  wire logic [BUS_W-1:0] secBus,
   input  wire logic [BUS_W-1:0] subBus,
   input  wire logic             memFwdHit,
   // primary address phase
   input  wire cwf_req_t         priReq,
   // claim decision, registered
   output logic                  claim,
   output cwf_action_t           action,
   // secondary address phase, registered
   output cwf_req_t             secReq
);
   ////////////////////////////////////////////////////////////////////////
   // address fields of the primary phase
   logic [1:0]       cfgType;
   logic [BUS_W-1:0] busField;
   logic [4:0]       devField;
   logic [2:0]       funcField;
   logic [5:0]       regField;
   // bus window and command decode
   logic             isSecondary;
   logic             isSubordinate;
   logic             isCfg;
   logic             isSpecialReq;
   // partial decisions
   cwf_action_t      type1Action;
   cwf_action_t      memAction;
   // state and next values
   logic             dacPhase_reg;
   cwf_action_t      action_next;
   cwf_req_t         secReq_next;
   logic [31:0]      idselOneHot;

   // type bits of a configuration phase
   assign cfgType   = priReq.addr[`CWF_TYPE_LSB +: `CWF_TYPE_W];
   // bus number of a type 1 phase picks the target bus
   assign busField  = priReq.addr[`CWF_BUS_LSB +: BUS_W];
   // device, function and register pick the target on that bus
   assign devField  = priReq.addr[`CWF_DEV_LSB +: `CWF_DEV_W];
   assign funcField = priReq.addr[`CWF_FUNC_LSB +: `CWF_FUNC_W];
   assign regField  = priReq.addr[`CWF_REG_LSB +: `CWF_REG_W];
   // reads and writes share one decode so type 0 writes match reads
   assign isCfg = (priReq.cmd == `CWF_CMD_CFG_WR)
               || (priReq.cmd == `CWF_CMD_CFG_RD);
   // special cycle request recognised by all-ones device and function
   assign isSpecialReq = (priReq.cmd == `CWF_CMD_CFG_WR)
                      && (devField == `CWF_DEV_ALL1)
                      && (funcField == `CWF_FUNC_ALL1);

   // compare the bus field with the secondary and subordinate numbers
   cwf_bus_match #(
      .BUS_W(BUS_W)
   ) uMatch (
      .targetBus    (busField),
      .secBus       (secBus),
      .subBus       (subBus),
      .isSecondary  (isSecondary),
      .isSubordinate(isSubordinate)
   );

   // one-hot select for the device line of the converted type 0 cycle;
   // only the low device bits reach a select line, so device numbers
   // sixteen apart share one line
   for (genvar i = 0; i < `CWF_ADDR_W; i++) begin : gIdsel
      if (i >= `CWF_IDSEL_LSB) begin : gLine
         assign idselOneHot[i] = (devField[`CWF_IDSEL_W-1:0]
                                 == (`CWF_IDSEL_W)'(i - `CWF_IDSEL_LSB));
      end else begin : gLow
         assign idselOneHot[i] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // action for a type 1 configuration phase from the bus window;
   // a special cycle request is only ever a write
   always_comb begin
      type1Action = CWF_IGNORE;
      if (isSpecialReq) begin
         if (isSecondary) begin
            type1Action = CWF_TO_SPECIAL;
         end else if (isSubordinate) begin
            type1Action = CWF_PASS_TYPE1;
         end else begin
            type1Action = CWF_IGNORE;
         end
      end else begin
         if (isSecondary) begin
            type1Action = CWF_TO_TYPE0;
         end else if (isSubordinate) begin
            type1Action = CWF_PASS_TYPE1;
         end else begin
            type1Action = CWF_IGNORE;
         end
      end
   end

   // memory phases follow the window decode made elsewhere in the bridge
   always_comb begin
      memAction = CWF_IGNORE;
      if (memFwdHit) begin
         memAction = CWF_PASS_MEM;
      end
   end

   // classify the address phase; the phase after a dual address phase
   // carries the high address and is never a command of its own
   always_comb begin
      action_next = CWF_IGNORE;
      if (priReq.valid && !dacPhase_reg) begin
         if (priReq.cmd == `CWF_CMD_DAC) begin
            action_next = memAction;
         end else if (isCfg && cfgType == `CWF_TYPE0) begin
            action_next = CWF_LOCAL;
         end else if (isCfg && cfgType == `CWF_TYPE1) begin
            action_next = type1Action;
         end else if (priReq.cmd == `CWF_CMD_MEM_RD
                   || priReq.cmd == `CWF_CMD_MEM_RDL) begin
            action_next = memAction;
         end
      end
   end

   // build the secondary address phase
   always_comb begin
      secReq_next = '0;
      case (action_next)
         CWF_TO_TYPE0: begin
            // type 0 form: select line, function, register, type bits
            secReq_next.valid = 1'b1;
            secReq_next.cmd   = priReq.cmd;
            secReq_next.addr  = idselOneHot
                              | {21'h0, funcField, regField,
                                 `CWF_TYPE0};
         end
         CWF_TO_SPECIAL: begin
            secReq_next.valid = 1'b1;
            secReq_next.cmd   = `CWF_CMD_SPECIAL;
            secReq_next.addr  = 32'h0000_0000;
         end
         CWF_PASS_TYPE1, CWF_PASS_MEM: begin
            secReq_next = priReq;
         end
         default: begin
            secReq_next = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // second address phase of a dual address cycle is not a new command;
   // the flag lasts exactly one cycle, so a run of dual address
   // commands alternates between low and high phases
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dacPhase_reg <= 1'b0;
      end else begin
         dacPhase_reg <= priReq.valid && !dacPhase_reg
                      && (priReq.cmd == `CWF_CMD_DAC);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // claim flag, high for one cycle after a claimed phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         claim <= 1'b0;
      end else begin
         claim <= (action_next != CWF_IGNORE);
      end
   end

   // decision code shown beside the claim flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         action <= CWF_IGNORE;
      end else begin
         action <= action_next;
      end
   end

   // forwarded phase on the secondary side, all zero when nothing goes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         secReq <= '0;
      end else begin
         secReq <= secReq_next;
      end
   end
endmodule

//--- bench/cwf_sec_target.sv
// secondary bus target model that records forwarded phases
`timescale 1ns/1ps
module cwf_sec_target
   import cwf_pkg::*;
(
   // bus side
   input  wire logic     clk,
   input  wire cwf_req_t secReq,
   // last phase seen
   output cwf_req_t      seenReq
);
   // latch each address phase shown on the secondary bus
   always_ff @(posedge clk)
      if (secReq.valid)
         seenReq <= secReq;
endmodule

//--- bench/cwf_forward_asserts.sv
// checker for the forwarding decode
`timescale 1ns/1ps
module cwf_forward_asserts
   import cwf_pkg::*;
#(
   parameter int BUS_W = 8
) (
   // clock, reset and inputs
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [BUS_W-1:0] secBus,
   input  wire logic [BUS_W-1:0] subBus,
   input  wire logic             memFwdHit,
   input  wire cwf_req_t         priReq,
   // decision
   input  wire logic             claim,
   input  var  cwf_action_t      action,
   input  wire cwf_req_t         secReq
);
   logic            dacReg;
   wire logic [7:0] bn = priReq.addr[23:16];
   wire logic       tk = priReq.valid && !dacReg;
   wire logic       t1 = tk && priReq.cmd == 4'hB && priReq.addr[1:0] == 2'h1;
   wire logic       sp = priReq.addr[15:8] == 8'hFF;
   wire logic       sb = bn > secBus && bn <= subBus;
   // the phase after a dual address phase carries the high address
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         dacReg <= 1'b0;
      else
         dacReg <= tk && priReq.cmd == 4'hD;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   type0_local_a: assert property (tk && priReq.cmd == 4'hB &&
      priReq.addr[1:0] == 2'h0 |=> claim && action == CWF_LOCAL)
      else $error("type 0 write not local");
   to_type0_a: assert property (t1 && bn == secBus && !sp |=>
      action == CWF_TO_TYPE0 && secReq.addr[1:0] == 2'h0)
      else $error("secondary write not type 0");
   pass_type1_a: assert property (t1 && sb |=>
      action == CWF_PASS_TYPE1 && secReq == $past(priReq))
      else $error("deeper write not passed");
   miss_ignore_a: assert property (t1 && bn != secBus && !sb |=>
      !claim && !secReq.valid) else $error("stray write claimed");
   special_gen_a: assert property (t1 && sp && bn == secBus |=>
      action == CWF_TO_SPECIAL && secReq.cmd == 4'h1)
      else $error("special cycle not made");
   dac_high_a: assert property (dacReg && priReq.valid |=> !claim)
      else $error("high address phase claimed");
   mem_line_a: assert property (tk && (priReq.cmd == 4'h6 ||
      priReq.cmd == 4'hE) |=> claim == $past(memFwdHit))
      else $error("memory read claim wrong");
   idle_quiet_a: assert property (!priReq.valid |=> !claim ##0 !secReq.valid)
      else $error("output without request");
   cover property (claim && action == CWF_TO_SPECIAL);
   cover property (claim && action == CWF_TO_TYPE0);
   cover property (dacReg && priReq.valid);
endmodule
bind cwf_forward cwf_forward_asserts #(.BUS_W(BUS_W)) chk (.clk(clk),
   .resetn(resetn), .secBus(secBus), .subBus(subBus), .memFwdHit(memFwdHit),
   .priReq(priReq), .claim(claim), .action(action), .secReq(secReq));

//--- bench/cwf_forward_bench.sv
// bench for the forwarding decode
`timescale 1ns/1ps
module cwf_forward_bench
   import cwf_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  secBus = 8'h04;
   logic [7:0]  subBus = 8'h09;
   logic        memFwdHit = 1'b0;
   cwf_req_t    priReq = '0;
   logic        claim;
   cwf_action_t action;
   cwf_req_t    secReq;
   cwf_req_t    seenReq;
   int          errCount = 0;
   int          checkCount = 0;
   int          cycles = 0;
   cwf_forward dut (.clk(clk), .resetn(resetn), .secBus(secBus),
      .subBus(subBus), .memFwdHit(memFwdHit), .priReq(priReq),
      .claim(claim), .action(action), .secReq(secReq));
   cwf_sec_target far (.clk(clk), .secReq(secReq), .seenReq(seenReq));
   // clock and hang guard
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         errCount++;
         tallyAndFinish();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(logic [69:0] got, logic [69:0] exp);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one primary phase, decision checked at the next falling edge
   task automatic op(logic v, logic [3:0] c, logic [31:0] a, logic cl,
                     cwf_action_t ac, logic [36:0] r);
      priReq = {v, c, a};
      @(negedge clk);
      cmp({claim, action, secReq.valid ? 37'(secReq) : 37'h0}, {cl, ac, r});
   endtask
   function automatic logic [31:0] t1a(logic [7:0] b, logic [4:0] d,
                                       logic [2:0] f);
      return {8'h00, b, d, f, 8'h09};
   endfunction
   function automatic logic [36:0] cv(logic [4:0] d, logic [2:0] f);
      return {5'h1B, (32'h1 << (16 + d[3:0])) | {21'h0, f, 8'h08}};
   endfunction
   task automatic scType0();
      op(1'b1, 4'hB, 32'h0000_0108, 1'b1, CWF_LOCAL, 37'h0);
      op(1'b1, 4'hA, 32'h0000_0108, 1'b1, CWF_LOCAL, 37'h0);
   endtask
   // mid-run reset clears every registered output at once
   task automatic scReset();
      op(1'b1, 4'hB, 32'h0000_0108, 1'b1, CWF_LOCAL, 37'h0);
      resetn = 1'b0;
      priReq = '0;
      #1 cmp({claim, action, 37'(secReq)}, {1'b0, CWF_IGNORE, 37'h0});
      @(negedge clk);
      resetn = 1'b1;
      op(1'b1, 4'hB, 32'h0000_0108, 1'b1, CWF_LOCAL, 37'h0);
   endtask
   task automatic scType1();
      op(1'b1, 4'hB, t1a(secBus, 5'h12, 3'h2), 1'b1, CWF_TO_TYPE0,
         cv(5'h12, 3'h2));
      op(1'b1, 4'hB, t1a(subBus, 5'h03, 3'h0), 1'b1, CWF_PASS_TYPE1,
         {5'h1B, t1a(subBus, 5'h03, 3'h0)});
      op(1'b1, 4'hB, t1a(subBus + 8'h01, 5'h03, 3'h0), 1'b0, CWF_IGNORE,
         37'h0);
      op(1'b1, 4'hB, t1a(secBus - 8'h01, 5'h03, 3'h0), 1'b0, CWF_IGNORE,
         37'h0);
   endtask
   task automatic scSpecial();
      op(1'b1, 4'hB, t1a(secBus, 5'h1F, 3'h6), 1'b1, CWF_TO_TYPE0,
         cv(5'h1F, 3'h6));
      op(1'b1, 4'hB, t1a(secBus, 5'h1F, 3'h7), 1'b1, CWF_TO_SPECIAL,
         {5'h11, 32'h0});
      op(1'b1, 4'hB, t1a(subBus, 5'h1F, 3'h7), 1'b1, CWF_PASS_TYPE1,
         {5'h1B, t1a(subBus, 5'h1F, 3'h7)});
      op(1'b1, 4'hB, t1a(8'h20, 5'h1F, 3'h7), 1'b0, CWF_IGNORE, 37'h0);
      op(1'b0, 4'h0, 32'h0, 1'b0, CWF_IGNORE, 37'h0);
      cmp(70'(seenReq), {33'h0, 5'h1B, t1a(subBus, 5'h1F, 3'h7)});
   endtask
   task automatic scMem();
      memFwdHit = 1'b1;
      op(1'b1, 4'hD, 32'h8000_0000, 1'b1, CWF_PASS_MEM,
         {5'h1D, 32'h8000_0000});
      op(1'b1, 4'hB, t1a(secBus, 5'h02, 3'h1), 1'b0, CWF_IGNORE,
         37'h0);
      for (int h = 0; h < 2; h++) begin
         memFwdHit = h[0];
         op(1'b1, 4'h6, 32'h40, h[0], h[0] ? CWF_PASS_MEM : CWF_IGNORE,
            h[0] ? {5'h16, 32'h40} : 37'h0);
         op(1'b1, 4'hE, 32'h40, h[0], h[0] ? CWF_PASS_MEM : CWF_IGNORE,
            h[0] ? {5'h1E, 32'h40} : 37'h0);
      end
      op(1'b0, 4'h0, 32'h0, 1'b0, CWF_IGNORE, 37'h0);
   endtask
   task automatic tallyAndFinish();
      if (errCount == 0 && checkCount > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // reset, then each scenario in turn
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      scType0();
      scReset();
      scType1();
      scSpecial();
      scMem();
      tallyAndFinish();
   end
endmodule
